// [src/adc_timing_format_control.sv]
// converter timing and result format control with axi4-lite registers
`timescale 1ns/1ps
`include "adc_ctl_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - timing register write aborts, no restart
// - resolution bit set gives 8-bit results
// - first sample phase lasts two conversion clocks
// - sample code picks 2,4,8,16 second-phase clocks
// - conversion clock is bus over 2*(prescaler+1)
// - prescaler resets to five, divide by twelve
// - sequence register write aborts and restarts
// - justify bit set gives right justification
// - sign bit gives offset two's complement left
// - right justified results are always unsigned
// - 8-bit left bits 15:8, right 7:0
// - 10-bit left bits 15:6, right 9:0
// - scan bit repeats sequences, else single
// - sequence write clears complete flags
// - timing write clears trigger overrun flag
module adc_timing_format_control import adc_ctl_pkg::*; #(
  parameter int SEQ_LEN = 4
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [`ADR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [`ADR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               trigger_overrun_event,
  input  wire core_result_t       core_res,
  output core_ctrl_t              core_ctl
);
  typedef struct packed {
    logic [7:0]        timing;
    logic [7:0]        seqctl;
    logic              sequence_complete_flag;
    logic              trigger_overrun_flag;
    logic [7:0]        ccf;
    logic [2:0]        idx;
    seq_state_t        st;
    logic [4:0]        ph;
    logic              abort;
    logic              aw_got;
    logic [`ADR_W-1:0] awaddr;
    logic              w_got;
    logic [7:0]        wdata;
    logic              wstb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0][15:0]  res;
  } ctl_state_t;

  ctl_state_t s_ff;
  ctl_state_t nxt_s;
  logic        tick;
  logic        do_wr;
  logic        tim_wr;
  logic        seq_wr;
  logic        sta_wr;
  logic [4:0]  ph2_len;
  logic [15:0] fmt_word;
  logic [2:0]  last_idx;

  // any aligned word in the map, results included
  function automatic logic is_mapped(input logic [`ADR_W-1:0] a);
    is_mapped = (a[1:0] == 2'b00) &&
                (a == `OFS_TIMING || a == `OFS_SEQ || a == `OFS_STATUS ||
                 a == `OFS_CCF || a >= `OFS_RES_BASE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  conv_clock_divider #(
    .PRS_W (5)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clock_divider_value     (s_ff.timing[`TIM_PRS_HI:`TIM_PRS_LO]),
    .restart (tim_wr || seq_wr),
    .tick    (tick)
  );

  result_formatter u_fmt (
    .raw                  (core_res.raw),
    .low_res              (s_ff.timing[`TIM_LOWRES_BIT]),
    .right_justify_select (s_ff.seqctl[`SEQ_RJ_BIT]),
    .signed_result_select (s_ff.seqctl[`SEQ_SGN_BIT]),
    .word                 (fmt_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes and write decode

  assign s_axi_awready = !s_ff.aw_got && !s_ff.bvalid;
  assign s_axi_wready  = !s_ff.w_got && !s_ff.bvalid;
  assign s_axi_arready = !s_ff.rvalid;
  assign s_axi_bvalid  = s_ff.bvalid;
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;

  // register bits sit in byte lane 0, so only wstrb[0] matters
  assign do_wr  = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
  assign tim_wr = do_wr && s_ff.wstb && s_ff.awaddr == `OFS_TIMING;
  assign seq_wr = do_wr && s_ff.wstb && s_ff.awaddr == `OFS_SEQ;
  assign sta_wr = do_wr && s_ff.wstb && s_ff.awaddr == `OFS_STATUS;

  // second phase is 2 << code: 2, 4, 8, 16 conversion clocks
  assign ph2_len  = `PH2_BASE << s_ff.timing[`TIM_SMP_HI:`TIM_SMP_LO];
  assign last_idx = 3'(SEQ_LEN - 1);

  assign core_ctl.conv_tick     = tick;
  assign core_ctl.sample_first  = s_ff.st == ST_SAMPLE1;
  assign core_ctl.sample_second = s_ff.st == ST_SAMPLE2;
  assign core_ctl.converting    = s_ff.st == ST_CONVERT;
  assign core_ctl.abort         = s_ff.abort;
  assign core_ctl.low_res       = s_ff.timing[`TIM_LOWRES_BIT];
  assign core_ctl.slot          = s_ff.idx;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_s       = s_ff;
    nxt_s.abort = tim_wr || seq_wr;
    // write channels are accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata[7:0];
      nxt_s.wstb  = s_axi_wstrb[0];
    end
    if (do_wr) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = is_mapped(s_ff.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      nxt_s.rdata  = 32'h0000_0000;
      if (s_axi_araddr == `OFS_TIMING) begin
        nxt_s.rdata[7:0] = s_ff.timing;
      end else if (s_axi_araddr == `OFS_SEQ) begin
        nxt_s.rdata[7:0] = s_ff.seqctl;
      end else if (s_axi_araddr == `OFS_STATUS) begin
        nxt_s.rdata[`STA_SCF_BIT]   = s_ff.sequence_complete_flag;
        nxt_s.rdata[`STA_TRIGGER_OVERRUN_FLAG_BIT] = s_ff.trigger_overrun_flag;
        nxt_s.rdata[2:0]            = s_ff.idx;
      end else if (s_axi_araddr == `OFS_CCF) begin
        nxt_s.rdata[7:0] = s_ff.ccf;
      end else if (is_mapped(s_axi_araddr)) begin
        nxt_s.rdata[15:0] = s_ff.res[s_axi_araddr[4:2]];
      end
    end else if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    // status flags clear on writing one
    if (sta_wr) begin
      if (s_ff.wdata[`STA_SCF_BIT]) begin
        nxt_s.sequence_complete_flag = 1'b0;
      end
      if (s_ff.wdata[`STA_TRIGGER_OVERRUN_FLAG_BIT]) begin
        nxt_s.trigger_overrun_flag = 1'b0;
      end
    end
    // sample and conversion sequencer
    unique case (s_ff.st)
      ST_IDLE: begin
        nxt_s.ph = 5'd0;
      end
      ST_SAMPLE1: begin
        if (tick) begin
          if (s_ff.ph == `PH1_TICKS - 5'd1) begin
            nxt_s.st = ST_SAMPLE2;
            nxt_s.ph = 5'd0;
          end else begin
            nxt_s.ph = s_ff.ph + 5'd1;
          end
        end
      end
      ST_SAMPLE2: begin
        if (tick) begin
          if (s_ff.ph == ph2_len - 5'd1) begin
            nxt_s.st = ST_CONVERT;
            nxt_s.ph = 5'd0;
          end else begin
            nxt_s.ph = s_ff.ph + 5'd1;
          end
        end
      end
      ST_CONVERT: begin
        if (core_res.done) begin
          nxt_s.res[s_ff.idx] = fmt_word;
          nxt_s.ccf[s_ff.idx] = 1'b1;
          if (s_ff.idx == last_idx) begin
            nxt_s.sequence_complete_flag = 1'b1;
            nxt_s.idx = 3'd0;
            // scan runs sequences back to back
            nxt_s.st  = s_ff.seqctl[`SEQ_SCAN_BIT] ? ST_SAMPLE1 : ST_IDLE;
          end else begin
            nxt_s.idx = s_ff.idx + 3'd1;
            nxt_s.st  = ST_SAMPLE1;
          end
        end
      end
    endcase
    // register writes win over the sequencer state; only a sequence write also overrides its flag sets
    if (tim_wr) begin
      nxt_s.timing = s_ff.wdata;
      nxt_s.st     = ST_IDLE;
      nxt_s.ph     = 5'd0;
      nxt_s.idx    = 3'd0;
      nxt_s.trigger_overrun_flag  = 1'b0;
    end
    if (seq_wr) begin
      nxt_s.seqctl = s_ff.wdata;
      nxt_s.st     = ST_SAMPLE1;
      nxt_s.ph     = 5'd0;
      nxt_s.idx    = 3'd0;
      nxt_s.sequence_complete_flag    = 1'b0;
      nxt_s.ccf    = 8'h00;
      nxt_s.trigger_overrun_flag  = 1'b0;
    end
    // an overrun arriving with its clear is kept
    if (trigger_overrun_event) begin
      nxt_s.trigger_overrun_flag = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff        <= '0;
      s_ff.timing <= `TIM_RESET;
      s_ff.seqctl <= `SEQ_RESET;
      s_ff.st     <= ST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_tim_abort;
    @(posedge aclk) disable iff (!aresetn)
      tim_wr && !seq_wr |=> s_ff.st == ST_IDLE && s_ff.abort;
  endproperty
  a_tim_abort: assert property (p_tim_abort) else $error("timing write did not abort");

  property p_seq_restart;
    @(posedge aclk) disable iff (!aresetn)
      seq_wr |=> s_ff.st == ST_SAMPLE1 && s_ff.idx == 3'd0 && s_ff.ph == 5'd0;
  endproperty
  a_seq_restart: assert property (p_seq_restart) else $error("sequence did not restart");

  property p_seq_clear;
    @(posedge aclk) disable iff (!aresetn)
      seq_wr |=> s_ff.sequence_complete_flag == 1'b0 && s_ff.ccf == 8'h00;
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("complete flags not cleared");

  property p_trigger_overrun_flag_clear;
    @(posedge aclk) disable iff (!aresetn)
      tim_wr && !trigger_overrun_event |=> !s_ff.trigger_overrun_flag;
  endproperty
  a_trigger_overrun_flag_clear: assert property (p_trigger_overrun_flag_clear) else $error("overrun not cleared");

  property p_phase1;
    @(posedge aclk) disable iff (!aresetn)
      $rose(core_ctl.sample_second) |->
        $past(s_ff.ph) == `PH1_TICKS - 5'd1 && $past(s_ff.st) == ST_SAMPLE1;
  endproperty
  a_phase1: assert property (p_phase1) else $error("first phase length wrong");

  property p_phase2;
    @(posedge aclk) disable iff (!aresetn)
      s_ff.st == ST_SAMPLE2 && !tick && !do_wr |=> s_ff.st == ST_SAMPLE2;
  endproperty
  a_phase2: assert property (p_phase2) else $error("second phase left early");

  property p_phase2_end;
    @(posedge aclk) disable iff (!aresetn)
      s_ff.st == ST_SAMPLE2 && tick && s_ff.ph == ph2_len - 5'd1 && !do_wr
        |=> s_ff.st == ST_CONVERT;
  endproperty
  a_phase2_end: assert property (p_phase2_end) else $error("second phase overran");

  property p_prs_reset;
    @(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> s_ff.timing == `TIM_RESET;
  endproperty
  a_prs_reset: assert property (p_prs_reset) else $error("prescaler reset value wrong");

  property p_single;
    @(posedge aclk) disable iff (!aresetn)
      s_ff.st == ST_CONVERT && core_res.done && s_ff.idx == last_idx && !do_wr
        |=> s_ff.sequence_complete_flag && s_ff.st == (s_ff.seqctl[`SEQ_SCAN_BIT] ? ST_SAMPLE1 : ST_IDLE);
  endproperty
  a_single: assert property (p_single) else $error("sequence end wrong");

  property p_right_unsigned;
    @(posedge aclk) disable iff (!aresetn)
      s_ff.seqctl[`SEQ_RJ_BIT] |->
        fmt_word[15:10] == 6'h00 && (!core_ctl.low_res || fmt_word[9:8] == 2'b00);
  endproperty
  a_right_unsigned: assert property (p_right_unsigned) else $error("right form bits wrong");

  property p_left8;
    @(posedge aclk) disable iff (!aresetn)
      core_ctl.low_res && !s_ff.seqctl[`SEQ_RJ_BIT] |->
        fmt_word[7:0] == 8'h00 &&
        fmt_word[15:8] == (core_res.raw[9:2] ^ {s_ff.seqctl[`SEQ_SGN_BIT], 7'h00});
  endproperty
  a_left8: assert property (p_left8) else $error("8-bit left form wrong");

  c_scan_loop: cover property (@(posedge aclk) disable iff (!aresetn)
    s_ff.sequence_complete_flag && s_ff.st == ST_SAMPLE1 && s_ff.seqctl[`SEQ_SCAN_BIT]);
  c_abort_run: cover property (@(posedge aclk) disable iff (!aresetn)
    tim_wr && s_ff.st == ST_CONVERT);
  c_done_single: cover property (@(posedge aclk) disable iff (!aresetn)
    s_ff.sequence_complete_flag && s_ff.st == ST_IDLE);
endmodule

// [src/adc_ctl_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef ADC_CTL_MAP_SVH
`define ADC_CTL_MAP_SVH

`define ADR_W          6
`define OFS_TIMING     6'h00
`define OFS_SEQ        6'h04
`define OFS_STATUS     6'h08
`define OFS_CCF        6'h0c
`define OFS_RES_BASE   6'h20

`define TIM_LOWRES_BIT 7
`define TIM_SMP_HI     6
`define TIM_SMP_LO     5
`define TIM_PRS_HI     4
`define TIM_PRS_LO     0
`define TIM_RESET      8'h05

`define SEQ_RJ_BIT     7
`define SEQ_SGN_BIT    6
`define SEQ_SCAN_BIT   5
`define SEQ_RESET      8'h00

`define STA_SCF_BIT    7
`define STA_TRIGGER_OVERRUN_FLAG_BIT  5

`define PH1_TICKS      5'd2
`define PH2_BASE       5'd2
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// [src/adc_ctl_pkg.sv]
// types shared by the converter control block and its helpers
package adc_ctl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE1 = 2'b01,
    ST_SAMPLE2 = 2'b10,
    ST_CONVERT = 2'b11
  } seq_state_t;

  // signals driven towards the analog core
  typedef struct packed {
    logic       conv_tick;
    logic       sample_first;
    logic       sample_second;
    logic       converting;
    logic       abort;
    logic       low_res;
    logic [2:0] slot;
  } core_ctrl_t;

  // answer from the analog core; raw is left aligned in 10 bits
  typedef struct packed {
    logic       done;
    logic [9:0] raw;
  } core_result_t;

endpackage

// [src/conv_clock_divider.sv]
// conversion clock enable: bus clock divided by 2*(prescaler+1)
`timescale 1ns/1ps
`include "adc_ctl_map.svh"
module conv_clock_divider import adc_ctl_pkg::*; #(
  parameter int PRS_W = 5
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [PRS_W-1:0] clock_divider_value,
  input  wire logic             restart,
  output logic                  tick
);
  typedef struct packed {
    logic [PRS_W:0] cnt;
    logic [7:0]     gap;
  } div_state_t;

  div_state_t s_ff;
  div_state_t nxt_s;
  logic [PRS_W:0] lim;

  // limit is 2*prs+1 so one tick every 2*(prs+1) clocks
  assign lim  = {clock_divider_value, 1'b1};
  assign tick = (s_ff.cnt == lim) && !restart;

  always_comb begin
    nxt_s = s_ff;
    if (restart || s_ff.cnt == lim) begin
      nxt_s.cnt = '0;
    end else begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
    // gap only feeds the period check
    nxt_s.gap = (tick || restart) ? 8'h01 : s_ff.gap + 8'h01;
  end

  // gap starts at one so the first period after reset measures like any other
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff.cnt <= '0;
      s_ff.gap <= 8'h01;
    end else begin
      s_ff <= nxt_s;
    end
  end

  property p_div_period;
    @(posedge aclk) disable iff (!aresetn)
      tick && !$past(restart) && $past(clock_divider_value) == clock_divider_value |-> s_ff.gap == 8'(lim) + 8'h01;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period wrong");
endmodule

// [src/result_formatter.sv]
// justification and sign formatting of one conversion result
`timescale 1ns/1ps
module result_formatter import adc_ctl_pkg::*; (
  input  wire logic [9:0]  raw,
  input  wire logic        low_res,
  input  wire logic        right_justify_select,
  input  wire logic        signed_result_select,
  output logic [15:0]      word
);
  logic sgn;

  // signed only exists in left justified form
  assign sgn = signed_result_select && !right_justify_select;

  always_comb begin
    word = 16'h0000; // unused bits read zero
    if (low_res) begin
      if (right_justify_select) begin
        word[7:0] = raw[9:2];
      end else begin
        word[15:8] = {raw[9] ^ sgn, raw[8:2]};
      end
    end else begin
      if (right_justify_select) begin
        word[9:0] = raw;
      end else begin
        word[15:6] = {raw[9] ^ sgn, raw[8:0]};
      end
    end
  end
endmodule

// [test/adc_core_model.sv]
// behavioural model of the analog sample and conversion core
`timescale 1ns/1ps
module adc_core_model import adc_ctl_pkg::*; #(
  parameter int CONV_CYCLES = 10
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire core_ctrl_t core_ctl,
  input  wire logic [9:0] raw_base,
  output core_result_t    core_res
);
  logic [7:0] cnt_ff;
  logic       done_ff;
  logic [9:0] val_ff;

  ////////////////////////////////////////////////////////////////////////////
  // count bus clocks while converting; an abort drops the pending result
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_ctl.converting || core_ctl.abort) begin
      cnt_ff  <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= cnt_ff + 8'h01;
      done_ff <= (cnt_ff == 8'(CONV_CYCLES - 1));
      if (cnt_ff == 8'(CONV_CYCLES - 1)) begin
        val_ff <= raw_base + {7'h00, core_ctl.slot};
      end
    end
  end

  // outside the done pulse the data lines show the inverse, never a stale value
  assign core_res.done = done_ff;
  assign core_res.raw  = done_ff ? val_ff : ~val_ff;
endmodule

// [test/tb.sv]
// self-checking bench for the converter timing and format control block
`timescale 1ns/1ps
module tb import adc_ctl_pkg::*; ;
  localparam int PRS_OK = 24; // 2 MHz at 100 MHz
  logic         aclk, aresetn, trig;
  logic [5:0]   awaddr, araddr;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [31:0]  wdata, rdata, rdv;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, resp;
  logic [9:0]   raw_base;
  core_result_t core_res;
  core_ctrl_t   core_ctl;
  int           err_total, check_count, n;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  adc_timing_format_control adc_timing_format_control_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_overrun_event(trig), .core_res(core_res), .core_ctl(core_ctl));

  adc_core_model adc_core_model_i (
    .aclk(aclk), .aresetn(aresetn), .core_ctl(core_ctl), .raw_base(raw_base),
    .core_res(core_res));

  //////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite master; readies sampled mid-cycle, so no race with the edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    // one edge between transfers so a release and the next raise never share a step
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid & awready;
      w_hs  = wvalid & wready;
      b_hs  = bvalid & bready;
      resp  = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid & arready;
      r_hs  = rvalid & rready;
      d     = rdata;
      r     = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // core-side observation helpers
  task automatic tick_gap(output int g);
    g = 0;
    do @(negedge aclk); while (core_ctl.conv_tick !== 1'b1);
    do begin
      @(negedge aclk);
      g++;
    end while (core_ctl.conv_tick !== 1'b1);
    @(posedge aclk);
  endtask

  // conversion ticks seen while one sample phase is active
  task automatic phase_ticks(input logic second, output int t);
    t = 0;
    do @(negedge aclk);
    while ((second ? core_ctl.sample_second : core_ctl.sample_first) !== 1'b1);
    while ((second ? core_ctl.sample_second : core_ctl.sample_first) === 1'b1) begin
      if (core_ctl.conv_tick === 1'b1) t++;
      @(negedge aclk);
    end
    @(posedge aclk);
  endtask

  // polling keeps the bus busy, which also exercises back-to-back reads
  task automatic wait_scf();
    rdv = 32'h0;
    for (int i = 0; i < 3000 && rdv[7] !== 1'b1; i++) rd(6'h08, rdv, resp);
  endtask

  function automatic logic [31:0] fmt(input logic [9:0] v, input logic lr, rj, sg);
    logic [15:0] w;
    if (lr) w = rj ? {8'h00, v[9:2]} : {v[9:2] ^ {sg, 7'h00}, 8'h00};
    else w = rj ? {6'h00, v} : {v ^ {sg, 9'h000}, 6'h00};
    return {16'h0000, w};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (80000) @(posedge aclk);
    err_total++;
    test_done();
  end

  // main sequence
  initial begin
    int prs_list[3];
    prs_list = '{0, 31, PRS_OK};
    {aresetn, trig, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    raw_base = 10'h2c5;
    err_total = 0;
    check_count = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(6'h00, rdv, resp);
    chk(rdv, 32'h05);
    rd(6'h04, rdv, resp);
    chk(rdv, 32'h00);
    tick_gap(n);
    chk(n, 12);
    rd(6'h10, rdv, resp);
    chk({30'h0, resp}, 32'h2);
    wr(6'h3e, 32'h0, 2'b10);
    // divider extremes and the in-range setting
    foreach (prs_list[i]) begin
      wr(6'h00, 32'(prs_list[i]), 2'b00);
      tick_gap(n);
      chk(n, 2 * (prs_list[i] + 1));
    end
    // every sample-time code; each timing write aborts the previous run
    for (int c = 0; c < 4; c++) begin
      wr(6'h00, 32'((c << 5) | PRS_OK), 2'b00);
      wr(6'h04, 32'h0, 2'b00);
      phase_ticks(1'b0, n);
      chk(n, 2);
      phase_ticks(1'b1, n);
      chk(n, 2 << c);
    end
    // all eight format settings, single sequences
    for (int f = 0; f < 8; f++) begin
      wr(6'h00, {24'h000000, f[2], 2'b00, 5'(PRS_OK)}, 2'b00);
      wr(6'h04, {24'h000000, f[1:0], 6'h00}, 2'b00);
      wait_scf();
      rd(6'h20, rdv, resp);
      chk(rdv, fmt(raw_base, f[2], f[1], f[0]));
      rd(6'h2c, rdv, resp);
      chk(rdv, fmt(raw_base + 10'h3, f[2], f[1], f[0]));
      rd(6'h0c, rdv, resp);
      chk(rdv, 32'h0f);
    end
    repeat (300) @(negedge aclk);
    chk({core_ctl.sample_first, core_ctl.sample_second, core_ctl.converting}, 0);
    @(posedge aclk);
    // restart after a finished sequence
    wr(6'h04, 32'h0, 2'b00);
    @(negedge aclk);
    chk(core_ctl.sample_first, 1);
    @(posedge aclk);
    rd(6'h08, rdv, resp);
    chk(rdv, 32'h0);
    rd(6'h0c, rdv, resp);
    chk(rdv, 32'h0);
    // overrun flag, then abort mid-sequence
    trig <= 1'b1;
    @(posedge aclk);
    trig <= 1'b0;
    rd(6'h08, rdv, resp);
    chk(rdv & 32'h20, 32'h20);
    wr(6'h00, 32'(PRS_OK), 2'b00);
    rd(6'h08, rdv, resp);
    chk(rdv & 32'h20, 32'h0);
    repeat (300) @(negedge aclk);
    chk({core_ctl.sample_first, core_ctl.sample_second, core_ctl.converting}, 0);
    @(posedge aclk);
    // continuous mode sets the flag again after it is cleared
    wr(6'h04, 32'h20, 2'b00);
    wait_scf();
    wr(6'h08, 32'h80, 2'b00);
    rd(6'h08, rdv, resp);
    chk(rdv & 32'h80, 32'h0);
    wait_scf();
    chk(rdv & 32'h80, 32'h80);
    test_done();
  end
endmodule
